// ### rtl/adcs_ctrl.sv
// Control of an 8-bit successive-approximation converter: registers, clocking, sequencing
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module adcs_ctrl (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       halt_mode,
    input  wire logic       wait_mode,
    input  wire logic       comp_in,
    input  wire logic [4:0] pin_in,
    output logic      [4:0] port_level,
    output logic      [2:0] chan_sel,
    output logic            conv_power,
    output logic            amp_power,
    output logic            amp_route,
    output logic            sample_en,
    output logic      [7:0] dac_code
);
    typedef struct packed {
        logic [7:0]                 rdata;
        logic                       done;
        logic                       speed;
        logic                       on;
        logic [2:0]                 chan;
        logic                       slow;
        logic                       amplifier_select;
        logic [7:0]                 result;
        adcs_pkg::adcs_phase_e      phase;
        logic [3:0]                 cnt;
        logic [1:0]                 div;
        logic [7:0]                 sar;
        logic [7:0]                 trial;
        logic [4:0]                 p1;
        logic [4:0]                 p2;
        logic [4:0]                 p3;
        logic [4:0]                 port;
        logic [2:0]                 chan_o;
        logic                       pwr;
        logic                       route;
        logic                       smp;
        logic [7:0]                 dac;
    } adcs_state_s;

    adcs_state_s st_ff;
    adcs_state_s nxt_st;
    logic        tick;
    logic        active;
    logic        csr_wr;
    logic        restart;

    // Register read, writes, clock division and sequencing
    always_comb begin
        nxt_st  = st_ff;
        active  = st_ff.on && !halt_mode;
        csr_wr  = wr && (addr == adcs_pkg::OFS_CONTROL_STATUS);
        restart = csr_wr && wdata[adcs_pkg::CSR_ON_BIT];
        // Converter clock enable from divider
        if (st_ff.slow) begin
            tick = (st_ff.div == 2'h3);
        end else if (st_ff.speed) begin
            tick = 1'b1;
        end else begin
            tick = st_ff.div[0];
        end
        nxt_st.div = st_ff.div + 2'h1;

        // Pin synchronisers, change taken when stages 2 and 3 agree
        nxt_st.p1 = pin_in;
        nxt_st.p2 = st_ff.p1;
        nxt_st.p3 = st_ff.p2;
        for (int i = 0; i < 5; i++) begin
            if (st_ff.p2[i] == st_ff.p3[i]) begin
                nxt_st.port[i] = st_ff.p3[i];
            end
        end
        // Read data, one cycle later; unmapped reads zero
        nxt_st.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                adcs_pkg::OFS_CONTROL_STATUS: nxt_st.rdata = {st_ff.done, st_ff.speed, st_ff.on, 2'h0, st_ff.chan};
                adcs_pkg::OFS_RESULT:         nxt_st.rdata = st_ff.result;
                adcs_pkg::OFS_AMP_CLOCK:      nxt_st.rdata = {4'h0, st_ff.slow, st_ff.amplifier_select, 2'h0};
                default:                      nxt_st.rdata = 8'h00;
            endcase
        end

        // Flag clears by software access
        if ((rd && addr == adcs_pkg::OFS_RESULT) || csr_wr) begin
            nxt_st.done = 1'b0;
        end
        if (csr_wr) begin
            nxt_st.speed = wdata[adcs_pkg::CSR_SPEED_BIT];
            nxt_st.on    = wdata[adcs_pkg::CSR_ON_BIT];
            nxt_st.chan  = wdata[adcs_pkg::CSR_CH_MSB:0];
        end
        if (wr && addr == adcs_pkg::OFS_AMP_CLOCK) begin
            nxt_st.slow   = wdata[adcs_pkg::AMP_SLOW_BIT];
            nxt_st.amplifier_select = wdata[adcs_pkg::AMP_SEL_BIT];
        end

        // Conversion sequencer
        if (!active) begin
            nxt_st.phase = adcs_pkg::ADCS_OFF;
            nxt_st.cnt   = 4'h0;
            nxt_st.sar   = 8'h00;
            nxt_st.trial = 8'h80;
        end else if (restart || st_ff.phase == adcs_pkg::ADCS_OFF) begin
            nxt_st.phase = adcs_pkg::ADCS_SAMPLE;
            nxt_st.cnt   = 4'h0;
            nxt_st.sar   = 8'h00;
            nxt_st.trial = 8'h80;
        end else if (tick) begin
            unique case (st_ff.phase)
                adcs_pkg::ADCS_SAMPLE: begin
                    if (st_ff.cnt == adcs_pkg::SAMPLE_CYCLES - 4'h1) begin
                        nxt_st.phase = adcs_pkg::ADCS_HOLD;
                        nxt_st.cnt   = 4'h0;
                    end else begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end
                end
                adcs_pkg::ADCS_HOLD: begin
                    // One approximation step per converter clock; comparator is strobed
                    // on this clock and read directly, since a pipeline would judge a stale trial
                    nxt_st.sar   = comp_in ? (st_ff.sar | st_ff.trial) : st_ff.sar;
                    nxt_st.trial = st_ff.trial >> 1;
                    nxt_st.cnt   = st_ff.cnt + 4'h1;
                    if (st_ff.cnt == adcs_pkg::HOLD_STEPS - 4'h1) begin
                        nxt_st.result = comp_in ? (st_ff.sar | st_ff.trial) : st_ff.sar;
                        nxt_st.done   = 1'b1;
                        nxt_st.phase  = adcs_pkg::ADCS_SAMPLE;
                        nxt_st.cnt    = 4'h0;
                        nxt_st.sar    = 8'h00;
                        nxt_st.trial  = 8'h80;
                    end
                end
                default: nxt_st.phase = adcs_pkg::ADCS_OFF;
            endcase
        end

        // Analog-side controls
        nxt_st.chan_o = (st_ff.chan > adcs_pkg::CH_MAX) ? adcs_pkg::CH_MAX : st_ff.chan;
        nxt_st.pwr    = active;
        nxt_st.route  = st_ff.amplifier_select;
        nxt_st.smp    = (nxt_st.phase == adcs_pkg::ADCS_SAMPLE);
        nxt_st.dac    = nxt_st.sar | nxt_st.trial;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff        <= '0;
            st_ff.phase  <= adcs_pkg::ADCS_OFF;
            st_ff.trial  <= 8'h80;
            st_ff.dac    <= 8'h80;
            st_ff.result <= adcs_pkg::RST_RESULT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata      = st_ff.rdata;
    assign port_level = st_ff.port;
    assign chan_sel   = st_ff.chan_o;
    assign conv_power = st_ff.pwr;
    assign amp_power  = st_ff.pwr;
    assign amp_route  = st_ff.route;
    assign sample_en  = st_ff.smp;
    assign dac_code   = st_ff.dac;
endmodule

// ### rtl/adcs_pkg.sv
// Package: register map, field positions, reset values and timing of the converter control
package adcs_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CONTROL_STATUS  = 8'h34;
    localparam logic [7:0] OFS_RESULT          = 8'h35;
    localparam logic [7:0] OFS_AMP_CLOCK       = 8'h36;
    // Control/status fields
    localparam int         CSR_DONE_BIT        = 7;
    localparam int         CSR_SPEED_BIT       = 6;
    localparam int         CSR_ON_BIT          = 5;
    localparam int         CSR_CH_MSB          = 2;
    // Amplifier/clock fields
    localparam int         AMP_SLOW_BIT        = 3;
    localparam int         AMP_SEL_BIT         = 2;
    // Reset values
    localparam logic [7:0] RST_CONTROL_STATUS  = 8'h00;
    localparam logic [7:0] RST_RESULT          = 8'h00;
    localparam logic [7:0] RST_AMP_CLOCK       = 8'h00;
    // Writable masks
    localparam logic [7:0] CSR_WMASK           = 8'h67;
    localparam logic [7:0] AMP_WMASK           = 8'h0C;
    // Highest legal channel code
    localparam logic [2:0] CH_MAX              = 3'h4;
    // Conversion timing in converter clock cycles
    localparam logic [3:0] SAMPLE_CYCLES       = 4'h4;
    localparam logic [3:0] HOLD_STEPS          = 4'h8;

    typedef enum logic [1:0] {
        ADCS_OFF,
        ADCS_SAMPLE,
        ADCS_HOLD
    } adcs_phase_e;
endpackage

// ### testbench/adcs_analog_model.sv
// Behavioural analog front end: input multiplexer, x8 gain stage and comparator
`timescale 1ns/1ps
module adcs_analog_model (
    input wire logic       clk,
    input wire logic [2:0] chan_sel,
    input wire logic       conv_power,
    input wire logic       amp_route,
    input wire logic [7:0] dac_code,
    output logic           comp_in
);
    logic [7:0]  level [5] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h20};
    logic [10:0] gained;
    logic        idle_q = 1'b0;
    // Channel pick, then optional gain of eight
    assign gained = amp_route ? {level[chan_sel], 3'h0} : {3'h0, level[chan_sel]};
    // Unpowered comparator output is meaningless, so it toggles
    always_ff @(posedge clk) idle_q <= ~idle_q;
    assign comp_in = conv_power ? (gained >= {3'h0, dac_code}) : idle_q;
endmodule

// ### testbench/adcs_ctrl_assertions.sv
// Assertion checker for the converter control ports
`timescale 1ns/1ps
module adcs_ctrl_assertions (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       halt_mode,
    input wire logic [4:0] pin_in,
    input wire logic [4:0] port_level,
    input wire logic [2:0] chan_sel,
    input wire logic       conv_power,
    input wire logic       amp_power,
    input wire logic       sample_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Power, channel range, sampling, port level and read port relations
    chk_power_pair: assert property (conv_power == amp_power)
        else $error("power pair split");
    chk_chan_range: assert property (chan_sel <= 3'h4)
        else $error("channel out of range");
    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without read");
    chk_amp_zero: assert property (rd && addr == 8'h36 |=> (rdata & 8'hF3) == 8'h00)
        else $error("amplifier reserved bits set");
    chk_halt_off: assert property (halt_mode |=> !conv_power)
        else $error("powered in halt");
    chk_power_follow: assert property (wr && addr == 8'h34 ##1 !halt_mode |=> conv_power == $past(wdata[5], 2))
        else $error("power not following on bit");
    chk_sample_off: assert property (!conv_power && $past(conv_power) == 1'b0 |-> !sample_en)
        else $error("sampling while off");
    chk_port_follow: assert property ($stable(pin_in)[*6] |-> port_level == pin_in)
        else $error("port level stale");
endmodule
bind adcs_ctrl adcs_ctrl_assertions chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .halt_mode(halt_mode), .pin_in(pin_in), .port_level(port_level), .chan_sel(chan_sel),
    .conv_power(conv_power), .amp_power(amp_power), .sample_en(sample_en));

// ### testbench/adcs_ctrl_tb_top.sv
// Testbench: register accesses and conversion checks for the converter control
`timescale 1ns/1ps
module adcs_ctrl_tb_top;
    logic       clk, resetn, wr, rd, halt_mode, wait_mode, comp_in, conv_power, amp_power, amp_route, sample_en;
    logic [7:0] addr, wdata, rdata, dac_code, got, prev;
    logic [4:0] pin_in, port_level;
    logic [2:0] chan_sel;
    // Amplifier entry uses the slowest converter clock
    logic [31:0] cfg [4] = '{32'h0820FF04, 32'h00210002, 32'h0062FF01, 32'h0C24FF04};
    int         errors, check_count, n;
    adcs_ctrl dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .halt_mode(halt_mode), .wait_mode(wait_mode), .comp_in(comp_in), .pin_in(pin_in), .port_level(port_level),
        .chan_sel(chan_sel), .conv_power(conv_power), .amp_power(amp_power), .amp_route(amp_route),
        .sample_en(sample_en), .dac_code(dac_code));
    adcs_analog_model front (.clk(clk), .chan_sel(chan_sel), .conv_power(conv_power), .amp_route(amp_route),
        .dac_code(dac_code), .comp_in(comp_in));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask
    // Poll control/status until the done flag shows
    task automatic wait_done();
        got = 8'h00;
        for (n = 0; n < 400 && got[7] !== 1'b1; n += 2)
            rreg(8'h34, got);
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        errors++;
        $display("FAIL watchdog expected done seen hang");
        stop_test();
    end
    // Main sequence
    initial begin
        {errors, check_count, prev} = 0;
        {resetn, wr, rd, addr, wdata, halt_mode, wait_mode} = 0;
        pin_in = 5'h15;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        wreg(8'h35, 8'h5A);
        for (int i = 0; i < 4; i++) begin
            rreg(8'h34 + i[7:0], got);
            check("reset value", 8'h00, got);
        end
        wreg(8'h36, 8'hFF);
        rreg(8'h36, got);
        check("amp mask", 8'h0C, got);
        wreg(8'h34, 8'hFF);
        rreg(8'h34, got);
        check("csr mask", 8'h67, got);
        check("chan clamp", 8'h04, {5'h00, chan_sel});
        wreg(8'h34, 8'h00);
        foreach (cfg[i]) begin
            wreg(8'h36, cfg[i][31:24]);
            wreg(8'h34, cfg[i][23:16]);
            rreg(8'h35, got);
            check("held result", prev, got);
            wait_done();
            check("conv time", 8'h01, {7'h00, n >= 12 * cfg[i][7:0] - 6 && n <= 12 * cfg[i][7:0] + 10});
            rreg(8'h35, got);
            wait_done();
            rreg(8'h35, got);
            check("result", cfg[i][15:8], got);
            rreg(8'h34, got);
            check("done cleared", cfg[i][23:16], got);
            prev = cfg[i][15:8];
        end
        check("amp route", 8'h01, {7'h00, amp_route});
        wreg(8'h34, 8'h60);
        #1;
        check("sampling", 8'h01, {7'h00, sample_en});
        halt_mode <= 1'b1;
        wait_mode <= 1'b1;
        pin_in    <= 5'h0A;
        repeat (100) @(posedge clk);
        check("port level", 8'h0A, {3'h0, port_level});
        check("halt power", 8'h00, {6'h00, conv_power, amp_power});
        check("halt idle", 8'h00, {7'h00, sample_en});
        check("idle trial", 8'h80, dac_code);
        rreg(8'h34, got);
        check("halted csr", 8'h60, got);
        halt_mode <= 1'b0;
        wait_done();
        check("wait done", 8'hE0, got);
        stop_test();
    end
endmodule
